// [dv/lpf_freeze_checker.sv]
`default_nettype none
module lpf_freeze_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic freeze_req_pin,
  input wire logic static_current_enable,
  input wire logic hskp_done,
  input wire logic hskp_req,
  input wire logic freeze_entered,
  input wire logic sys_clk_gated,
  input wire logic static_current_access_macro,
  input wire logic scan_hold,
  input wire logic exit_settled
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_gate; $rose(freeze_entered) |-> sys_clk_gated && hskp_req; endproperty
  a_gate: assert property (p_gate) else $error("entered early");
  property p_rel; $fell(freeze_entered) |-> !$past(freeze_req_pin); endproperty
  a_rel: assert property (p_rel) else $error("left early");
  property p_qual; $rose(hskp_req) |-> $past(freeze_req_pin, 8); endproperty
  a_qual: assert property (p_qual) else $error("short qualify");
  property p_blk; $rose(hskp_req) |-> $past(static_current_enable); endproperty
  a_blk: assert property (p_blk) else $error("not blocked");
  property p_scan; freeze_entered |-> scan_hold && sys_clk_gated; endproperty
  a_scan: assert property (p_scan) else $error("scan or gate");
  property p_exit; $fell(freeze_entered) |-> !exit_settled [*8]; endproperty
  a_exit: assert property (p_exit) else $error("exit lag");
  property p_drop; $fell(hskp_req) |-> !freeze_entered && !sys_clk_gated; endproperty
  a_drop: assert property (p_drop) else $error("drop order");
  property p_mac; static_current_enable && freeze_entered |-> static_current_access_macro;
  endproperty
  a_mac: assert property (p_mac) else $error("macro");
endmodule
bind lpf_freeze_ctrl lpf_freeze_checker chk_u (.mclk, .nrst, .freeze_req_pin,
  .static_current_enable, .hskp_done, .hskp_req, .freeze_entered, .sys_clk_gated,
  .static_current_access_macro, .scan_hold, .exit_settled);
`default_nettype wire

// [dv/lpf_user_model.sv]
`default_nettype none
module lpf_user_model (
  input wire logic mclk,
  input wire logic hskp_req,
  input wire logic slow,
  output logic hskp_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  always_ff @(posedge mclk) cnt_r <= hskp_req ? cnt_r + {3'h0, cnt_r != 4'hF} : 4'h0;
  // slow mode stands for real shutdown work; fast mode is the loopback
  assign hskp_done = slow ? (cnt_r == 4'hF) : hskp_req;
endmodule
`default_nettype wire

// [dv/tb_low_power_freeze_entry_controller.sv]
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t value", $time); end end
module tb_low_power_freeze_entry_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0, nrst = 1'h0, pin = 1'h0, en = 1'h1, slow = 1'h0;
  logic done, req, frz, gated, macro, hold, settled;
  int n_mismatch = 0, checks = 0, n;
  always #5 mclk = ~mclk;
  lpf_freeze_ctrl dut_u (.mclk(mclk), .nrst(nrst), .freeze_req_pin(pin),
    .static_current_enable(en), .hskp_done(done), .hskp_req(req), .freeze_entered(frz),
    .sys_clk_gated(gated), .static_current_access_macro(macro), .scan_hold(hold),
    .exit_settled(settled));
  lpf_user_model user_u (.mclk(mclk), .hskp_req(req), .slow(slow), .hskp_done(done));
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wait_sig(input int s);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (n > 300) begin
        n_mismatch++;
        report_and_stop;
      end
    end while ((s == 0 ? req : s == 1 ? frz : settled) !== 1'h1);
  endtask
  task enter(input logic s);
    @(posedge mclk);
    slow <= s;
    pin <= 1'h1;
    wait_sig(0);
    `CHK(n >= 10, 1'h1)
    repeat (4) @(negedge mclk);
    `CHK(frz, ~s)
    wait_sig(1);
    `CHK({gated, hold, macro}, 3'h7)
    // every input of the bench stays still while frozen
    repeat (30) @(negedge mclk);
    `CHK(frz, 1'h1)
    @(posedge mclk);
    pin <= 1'h0;
    wait_sig(2);
    `CHK(n >= 20, 1'h1)
    `CHK({req, frz, gated}, 3'h0)
  endtask
  // a short or blocked request must never reach housekeeping
  task pulse(input logic e, input int len);
    logic seen;
    seen = 1'h0;
    @(posedge mclk);
    en <= e;
    pin <= 1'h1;
    repeat (len) @(posedge mclk);
    pin <= 1'h0;
    repeat (30) begin
      @(negedge mclk);
      seen = seen | req | frz;
    end
    `CHK(seen, 1'h0)
    `CHK(macro, e)
    @(posedge mclk);
    en <= 1'h1;
  endtask
  // reset taken while frozen and let go after the pin has dropped
  task reset_frozen;
    @(posedge mclk);
    slow <= 1'h0;
    pin <= 1'h1;
    wait_sig(1);
    @(posedge mclk);
    nrst <= 1'h0;
    pin <= 1'h0;
    repeat (2) @(negedge mclk);
    `CHK({req, frz, gated, settled}, 4'h1)
    @(posedge mclk);
    nrst <= 1'h1;
    repeat (4) @(negedge mclk);
    `CHK({req, frz, gated, settled}, 4'h1)
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'h1;
    repeat (4) @(negedge mclk);
    `CHK(settled, 1'h1)
    enter(1'h0);
    enter(1'h1);
    pulse(1'h1, 4);
    pulse(1'h0, 40);
    reset_frozen;
    enter(1'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire

// [include/lpf_consts.svh]
// Overview of operation
// - controller is a fully encoded state machine with a three-bit state register
// - idle until freeze request, then confirm it persists for a qualification interval
// - after qualification raise active-high housekeeping request on the system clock
// - without housekeeping, request output is looped back to complete input
// - gate all system clocks cleanly before freeze, restore cleanly on exit; here the one gate runs on mclk and its clk_out is left unconnected
// - freeze-entered output rises only after housekeeping and clock gating complete
// - freeze-entered stays high through freeze, released only when request drops
// - static current enable low blocks the freeze pin, high lets it act
// - on exit outputs may trail inputs by up to 200 ns
// - registers and memory contents are retained across freeze
// - boundary-scan state machine stays powered but does not advance in freeze
`ifndef LPF_CONSTS_SVH
`define LPF_CONSTS_SVH
`define LPF_CLK_NS 10
`define LPF_QUAL_NS 80
`define LPF_QUAL_CYC ((`LPF_QUAL_NS + `LPF_CLK_NS - 1) / `LPF_CLK_NS)
`define LPF_EXIT_LAG_NS 200
`define LPF_EXIT_LAG_CYC ((`LPF_EXIT_LAG_NS + `LPF_CLK_NS - 1) / `LPF_CLK_NS)
`define LPF_CNT_W 5
`define LPF_SETTLED_RST 1'h1
`endif

// [include/lpf_pkg.sv]
`default_nettype none
package lpf_pkg;
  typedef enum logic [2:0] {
    LPF_IDLE = 3'h0,
    LPF_QUAL = 3'h1,
    LPF_HSKP = 3'h2,
    LPF_GATE = 3'h3,
    LPF_FROZEN = 3'h4,
    LPF_UNGATE = 3'h5,
    LPF_EXIT = 3'h6
  } lpf_state_t;
  typedef struct packed {
    logic hskp_req;
    logic freeze_entered;
    logic clk_gate_req;
    logic static_current_enable;
  } lpf_ctl_t;
endpackage
`default_nettype wire

// [rtl/lpf_clk_gate.sv]
`default_nettype none
// glitch-free gate: enable is retimed on the falling edge so it only
// changes while the clock is low, so no runt pulse leaves the gate
module lpf_clk_gate (
  input wire logic clk_in,
  input wire logic rst_n,
  input wire logic gate_req,
  output logic gated_off,
  output logic clk_out
);
  logic en_r;
  logic en_nxt;
  always_comb begin
    en_nxt = ~gate_req;
  end
  always_ff @(negedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'h1;
    end else begin
      en_r <= en_nxt;
    end
  end
  assign clk_out = clk_in & en_r;
  assign gated_off = ~en_r;
endmodule
`default_nettype wire

// [rtl/lpf_freeze_ctrl.sv]
`include "lpf_consts.svh"
`default_nettype none
module lpf_freeze_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic freeze_req_pin,
  input wire logic static_current_enable,
  input wire logic hskp_done,
  output logic hskp_req,
  output logic freeze_entered,
  output logic sys_clk_gated,
  output logic static_current_access_macro,
  output logic scan_hold,
  output logic exit_settled
);
  // reset is taken at once and let go two mclk edges later, so no flop
  // leaves reset close to a clock edge
  logic [1:0] rst_sync_r;
  logic [1:0] rst_sync_nxt;
  logic rst_n;

  always_comb begin
    rst_sync_nxt = {rst_sync_r[0], 1'h1};
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= rst_sync_nxt;
    end
  end

  assign rst_n = rst_sync_r[1];

  // the request pin is asynchronous and passes two flops; the enable and
  // hskp_done come from logic on mclk and are read as they stand
  logic [1:0] pin_sync_r;
  logic [1:0] pin_sync_nxt;
  logic pin_q;

  always_comb begin
    pin_sync_nxt = {pin_sync_r[0], freeze_req_pin};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= pin_sync_nxt;
    end
  end

  assign pin_q = pin_sync_r[1];

  // the hard block ands the enable with the pin as well, so a low enable
  // must keep the request out of the state machine too
  logic req_ok;
  logic done_q;
  assign req_ok = pin_q & static_current_enable;
  // a looped-back request reads as done in the same cycle it is raised
  assign done_q = hskp_done;

  lpf_pkg::lpf_state_t st_r;
  lpf_pkg::lpf_state_t st_nxt;
  logic [`LPF_CNT_W-1:0] cnt_r;
  logic [`LPF_CNT_W-1:0] cnt_nxt;
  lpf_pkg::lpf_ctl_t ctl_r;
  lpf_pkg::lpf_ctl_t ctl_nxt;
  logic settled_r;
  logic settled_nxt;
  logic qual_end;
  logic lag_end;
  logic gated_off;

  assign qual_end = (cnt_r == `LPF_CNT_W'(`LPF_QUAL_CYC - 1));
  assign lag_end = (cnt_r == `LPF_CNT_W'(`LPF_EXIT_LAG_CYC - 1));

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      lpf_pkg::LPF_IDLE: begin
        if (req_ok) begin
          st_nxt = lpf_pkg::LPF_QUAL;
        end
      end
      lpf_pkg::LPF_QUAL: begin
        if (!req_ok) begin
          st_nxt = lpf_pkg::LPF_IDLE;
        end else if (qual_end) begin
          st_nxt = lpf_pkg::LPF_HSKP;
        end
      end
      lpf_pkg::LPF_HSKP: begin
        if (!req_ok) begin
          st_nxt = lpf_pkg::LPF_IDLE;
        end else if (done_q) begin
          st_nxt = lpf_pkg::LPF_GATE;
        end
      end
      lpf_pkg::LPF_GATE: begin
        if (gated_off) begin
          st_nxt = lpf_pkg::LPF_FROZEN;
        end
      end
      lpf_pkg::LPF_FROZEN: begin
        if (!pin_q) begin
          st_nxt = lpf_pkg::LPF_UNGATE;
        end
      end
      lpf_pkg::LPF_UNGATE: begin
        if (!gated_off) begin
          st_nxt = lpf_pkg::LPF_EXIT;
        end
      end
      lpf_pkg::LPF_EXIT: begin
        // outputs may trail inputs after exit; new requests wait it out
        if (lag_end) begin
          st_nxt = lpf_pkg::LPF_IDLE;
        end
      end
      default: begin
        st_nxt = lpf_pkg::LPF_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= lpf_pkg::LPF_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // one counter serves the qualify and the exit waits; both are entered
  // from a state that leaves it cleared
  always_comb begin
    cnt_nxt = '0;
    case (st_r)
      lpf_pkg::LPF_QUAL: begin
        if (req_ok && !qual_end) begin
          cnt_nxt = cnt_r + `LPF_CNT_W'(1);
        end
      end
      lpf_pkg::LPF_EXIT: begin
        if (!lag_end) begin
          cnt_nxt = cnt_r + `LPF_CNT_W'(1);
        end
      end
      default: begin
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_comb begin
    ctl_nxt = ctl_r;
    ctl_nxt.static_current_enable = static_current_enable;
    case (st_r)
      lpf_pkg::LPF_IDLE: begin
      end
      lpf_pkg::LPF_QUAL: begin
        if (req_ok && qual_end) begin
          ctl_nxt.hskp_req = 1'h1;
        end
      end
      lpf_pkg::LPF_HSKP: begin
        if (!req_ok) begin
          ctl_nxt.hskp_req = 1'h0;
        end else if (done_q) begin
          ctl_nxt.clk_gate_req = 1'h1;
        end
      end
      lpf_pkg::LPF_GATE: begin
        if (gated_off) begin
          ctl_nxt.freeze_entered = 1'h1;
        end
      end
      lpf_pkg::LPF_FROZEN: begin
        if (!pin_q) begin
          ctl_nxt.freeze_entered = 1'h0;
          ctl_nxt.clk_gate_req = 1'h0;
        end
      end
      lpf_pkg::LPF_UNGATE: begin
        if (!gated_off) begin
          ctl_nxt.hskp_req = 1'h0;
        end
      end
      lpf_pkg::LPF_EXIT: begin
      end
      default: begin
        ctl_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // status leaves the block from a flop; it follows the state register
  // edge for edge, so it is high exactly while the machine is idle
  always_comb begin
    settled_nxt = (st_nxt == lpf_pkg::LPF_IDLE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      settled_r <= `LPF_SETTLED_RST;
    end else begin
      settled_r <= settled_nxt;
    end
  end

  // only the gate state is observed here; the gated clock output is left unconnected
  lpf_clk_gate u_gate (
    .clk_in(mclk),
    .rst_n(rst_n),
    .gate_req(ctl_r.clk_gate_req),
    .gated_off(gated_off),
    .clk_out()
  );

  // state is held by clock gating only, never by reset, so contents survive
  assign hskp_req = ctl_r.hskp_req;
  assign freeze_entered = ctl_r.freeze_entered;
  assign sys_clk_gated = gated_off;
  assign static_current_access_macro = ctl_r.static_current_enable;
  assign scan_hold = ctl_r.freeze_entered;
  assign exit_settled = settled_r;
endmodule
`default_nettype wire
